// ===== rtl/serial_port_pkg.sv
package serial_port_pkg;

    typedef enum logic [2:0] {
        FMT_I2S,
        FMT_LEFT,
        FMT_RIGHT,
        FMT_TDM_CLOCK,
        FMT_TDM_PULSE
    } fmt_t;

    // Register map
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] TX_BASE     = 8'h20;
    localparam logic [7:0] RX_BASE     = 8'h40;

    // Control fields
    localparam int         CTRL_W      = 7;
    localparam int         FMT_LSB     = 0;
    localparam int         RJS_LSB     = 3;
    localparam int         MASTER_BIT  = 5;
    localparam int         ENABLE_BIT  = 6;
    localparam logic [6:0] CTRL_RESET  = 7'h00;

    // Frame geometry
    localparam int         LINES       = 4;
    localparam int         SLOTS       = 8;
    localparam int         WORD_MAX    = 24;
    localparam int         SLOT_LEN    = 32;
    localparam logic [7:0] LAST_2CH    = 8'h3f;
    localparam logic [7:0] LAST_TDM    = 8'hff;
    localparam logic [4:0] TOP_BIT     = 5'h17;
    localparam logic [4:0] WORD_LIMIT  = 5'h18;

    // MSB delay from the frame clock edge, in bit clocks
    localparam logic [4:0] MSB_ONE     = 5'h01;
    localparam logic [4:0] MSB_LEFT    = 5'h00;
    localparam logic [4:0] RJ_DLY_8    = 5'h08;
    localparam logic [4:0] RJ_DLY_12   = 5'h0c;
    localparam logic [4:0] RJ_DLY_16   = 5'h10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== rtl/serial_audio_port.sv
// Functional notes
// - Converter connects only to input frame clock, bit clock and data lines.
// - Output bit and frame clocks configurable as master or slave.
// - Processed audio leaves on four output data lines, on line 0 only in TDM.
// - Data changes on falling bit clock; receiver samples on rising.
// - I2S: frame on falling frame clock, MSB one bit later.
// - Left-justified: frame on rising frame clock, MSB aligned.
// - Right-justified: rising edge, MSB delayed 8, 12 or 16 bits.
// - TDM clock: frame on falling edge, first MSB one bit later.
// - TDM pulse: frame on rising pulse edge, first MSB one bit later.
// - TDM slots 0-3 in first half, 4-7 in second half.
// - Words up to 24 bits; extra bits dropped silently.
module serial_audio_port #(
    parameter int BCLK_HALF = 4
) (
    // System
    input  wire logic                                core_clk,
    input  wire logic                                srst,
    // AXI4-Lite slave
    input  wire logic [serial_port_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [serial_port_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    // Output port clocks, two-way
    input  wire logic                                out_bclk_in,
    output logic                                     out_bclk_out,
    output logic                                     out_bclk_oe,
    input  wire logic                                out_lrclk_in,
    output logic                                     out_lrclk_out,
    output logic                                     out_lrclk_oe,
    // Output port data
    output logic [3:0]                               serial_out_line,
    // Input port, clocked by the converter
    input  wire logic                                rx_bit_clk,
    input  wire logic                                in_frame_clk,
    input  wire logic [3:0]                          serial_in_line
);

    localparam logic [7:0] DIV_LAST = 8'(BCLK_HALF - 1);

    // {last bit, hit, slot, bit index} for a frame position
    function automatic logic [9:0] bit_map(
        input serial_port_pkg::fmt_t f,
        input logic [1:0]            rjs,
        input logic [7:0]            p
    );
        logic [4:0] msb;
        logic [4:0] lim;
        logic [4:0] off;
        logic       hit;
        unique case (f)
            serial_port_pkg::FMT_LEFT:  msb = serial_port_pkg::MSB_LEFT;
            serial_port_pkg::FMT_RIGHT: begin
                unique case (rjs)
                    2'h0:    msb = serial_port_pkg::RJ_DLY_8;
                    2'h1:    msb = serial_port_pkg::RJ_DLY_12;
                    default: msb = serial_port_pkg::RJ_DLY_16;
                endcase
            end
            default:                    msb = serial_port_pkg::MSB_ONE;
        endcase
        // Right-justified words end on the last bit of the half
        lim = (f == serial_port_pkg::FMT_RIGHT) ?
              5'(serial_port_pkg::SLOT_LEN - int'(msb)) :
              serial_port_pkg::WORD_LIMIT;
        off = p[4:0] - msb;
        hit = (p[4:0] >= msb) && (off < lim);
        return {hit && (off == lim - 5'h01), hit,
                is_tdm(f) ? p[7:5] : {2'h0, p[5]},
                serial_port_pkg::TOP_BIT - off};
    endfunction

    function automatic logic is_tdm(input serial_port_pkg::fmt_t f);
        return (f == serial_port_pkg::FMT_TDM_CLOCK) ||
               (f == serial_port_pkg::FMT_TDM_PULSE);
    endfunction

    function automatic logic [7:0] last_pos(input serial_port_pkg::fmt_t f);
        return is_tdm(f) ? serial_port_pkg::LAST_TDM :
                           serial_port_pkg::LAST_2CH;
    endfunction

    // Frame opens on a falling frame clock in I2S and TDM-clock modes
    function automatic logic falls_open(input serial_port_pkg::fmt_t f);
        return (f == serial_port_pkg::FMT_I2S) ||
               (f == serial_port_pkg::FMT_TDM_CLOCK);
    endfunction

    // {line used, slot index} for a data line
    function automatic logic [3:0] slot_of(
        input logic       tdm,
        input logic [1:0] k,
        input logic [2:0] s
    );
        if (tdm) begin
            return {k == 2'h0, s};
        end
        return {1'b1, k, s[0]};
    endfunction

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Control and data storage
    logic [serial_port_pkg::CTRL_W-1:0] ctrl_reg;
    logic [23:0] tx_slot_reg [serial_port_pkg::SLOTS];
    logic [23:0] rx_slot_reg [serial_port_pkg::SLOTS];
    logic [7:0]  tx_frames_reg;
    logic [7:0]  rx_frames_reg;

    serial_port_pkg::fmt_t fmt;
    logic [1:0]            rjs;
    logic                  master;
    logic                  enable;

    assign fmt    = serial_port_pkg::fmt_t'(ctrl_reg[2:0]);
    assign rjs    = ctrl_reg[serial_port_pkg::RJS_LSB +: 2];
    assign master = ctrl_reg[serial_port_pkg::MASTER_BIT];
    assign enable = ctrl_reg[serial_port_pkg::ENABLE_BIT];

    // AXI4-Lite slave
    logic [serial_port_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        do_write;
    logic        wr_ctrl;
    logic        wr_tx;
    logic        wr_ro;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;

    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ctrl  = aw_addr_reg == serial_port_pkg::CTRL_OFS;
    assign wr_tx    = aw_addr_reg[7:5] == serial_port_pkg::TX_BASE[7:5] &&
                      aw_addr_reg[1:0] == 2'h0;
    assign wr_ro    = aw_addr_reg == serial_port_pkg::STATUS_OFS ||
                      (aw_addr_reg[7:5] == serial_port_pkg::RX_BASE[7:5] &&
                       aw_addr_reg[1:0] == 2'h0);

    // Address and data are taken in either order, one write at a time
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= serial_port_pkg::RESP_OKAY;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= (wr_ctrl || wr_tx || wr_ro) ?
                                 serial_port_pkg::RESP_OKAY :
                                 serial_port_pkg::RESP_DECERR;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_reg <= serial_port_pkg::CTRL_RESET;
            for (int i = 0; i < serial_port_pkg::SLOTS; i++) begin
                tx_slot_reg[i] <= '0;
            end
        end else if (do_write && wr_ctrl) begin
            ctrl_reg <= 7'(apply_strb(32'(ctrl_reg), w_data_reg,
                                      w_strb_reg));
        end else if (do_write && wr_tx) begin
            tx_slot_reg[aw_addr_reg[4:2]] <=
                24'(apply_strb(32'(tx_slot_reg[aw_addr_reg[4:2]]),
                               w_data_reg, w_strb_reg));
        end
    end

    always_comb begin
        rd_data = '0;
        rd_resp = serial_port_pkg::RESP_OKAY;
        if (s_axi_araddr == serial_port_pkg::CTRL_OFS) begin
            rd_data = 32'(ctrl_reg);
        end else if (s_axi_araddr == serial_port_pkg::STATUS_OFS) begin
            rd_data = {16'h0000, tx_frames_reg, rx_frames_reg};
        end else if (s_axi_araddr[1:0] != 2'h0) begin
            rd_resp = serial_port_pkg::RESP_DECERR;
        end else if (s_axi_araddr[7:5] == serial_port_pkg::TX_BASE[7:5]) begin
            rd_data = 32'(tx_slot_reg[s_axi_araddr[4:2]]);
        end else if (s_axi_araddr[7:5] == serial_port_pkg::RX_BASE[7:5]) begin
            rd_data = 32'(rx_slot_reg[s_axi_araddr[4:2]]);
        end else begin
            rd_resp = serial_port_pkg::RESP_DECERR;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= serial_port_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Output port clocking
    logic [2:0] bclk_sync_reg;
    logic [2:0] lrclk_sync_reg;
    logic       bclk_st_reg;
    logic       lrclk_st_reg;
    logic [7:0] div_cnt_reg;
    logic       mbclk_reg;
    logic       b_agree;
    logic       l_agree;
    logic       lr_val;
    logic       tx_rise;
    logic       tx_fall;
    logic       m_tick;

    assign b_agree = bclk_sync_reg[1] == bclk_sync_reg[2];
    assign l_agree = lrclk_sync_reg[1] == lrclk_sync_reg[2];
    assign lr_val  = l_agree ? lrclk_sync_reg[2] : lrclk_st_reg;
    assign m_tick  = div_cnt_reg == DIV_LAST;
    assign tx_rise = enable && (master ? (m_tick && !mbclk_reg) :
                     (b_agree && bclk_sync_reg[2] && !bclk_st_reg));
    assign tx_fall = enable && (master ? (m_tick && mbclk_reg) :
                     (b_agree && !bclk_sync_reg[2] && bclk_st_reg));

    // Pin filters: an edge counts once the last two stages agree
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bclk_sync_reg  <= '0;
            lrclk_sync_reg <= '0;
            bclk_st_reg    <= 1'b0;
            lrclk_st_reg   <= 1'b0;
        end else begin
            bclk_sync_reg  <= {bclk_sync_reg[1:0], out_bclk_in};
            lrclk_sync_reg <= {lrclk_sync_reg[1:0], out_lrclk_in};
            if (b_agree) begin
                bclk_st_reg <= bclk_sync_reg[2];
            end
            lrclk_st_reg <= lr_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !enable || !master) begin
            div_cnt_reg <= '0;
            mbclk_reg   <= 1'b0;
        end else if (m_tick) begin
            div_cnt_reg <= '0;
            mbclk_reg   <= !mbclk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // Transmitter
    logic [7:0] tx_pos_reg;
    logic [7:0] tx_npos;
    logic       tx_prev_lr_reg;
    logic       tx_edge;
    logic       lr_gen;
    logic [9:0] tx_map;
    logic [3:0] tx_sl [serial_port_pkg::LINES];

    assign tx_npos = (tx_pos_reg == last_pos(fmt)) ? 8'h00 :
                     tx_pos_reg + 8'h01;
    assign tx_edge = falls_open(fmt) ? (tx_prev_lr_reg && !lr_val) :
                                       (!tx_prev_lr_reg && lr_val);
    assign tx_map  = bit_map(fmt, rjs, tx_npos);

    always_comb begin
        unique case (fmt)
            // frame clock falls at frame start
            serial_port_pkg::FMT_I2S:       lr_gen = tx_npos[5];
            // falls at frame start, high in second half
            serial_port_pkg::FMT_TDM_CLOCK: lr_gen = tx_npos[7];
            // one bit wide pulse at frame start
            serial_port_pkg::FMT_TDM_PULSE: lr_gen = tx_npos == 8'h00;
            default:                        lr_gen = !tx_npos[5];
        endcase
        for (int k = 0; k < serial_port_pkg::LINES; k++) begin
            tx_sl[k] = slot_of(is_tdm(fmt), 2'(k), tx_map[7:5]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !enable) begin
            tx_pos_reg      <= last_pos(fmt);
            tx_prev_lr_reg  <= 1'b0;
            serial_out_line <= '0;
            out_lrclk_out   <= 1'b0;
        end else begin
            // Slave: resync the free-running position on a frame edge
            if (tx_rise && !master) begin
                tx_prev_lr_reg <= lr_val;
                if (tx_edge) begin
                    tx_pos_reg <= 8'h00;
                end
            end
            if (tx_fall) begin
                tx_pos_reg <= tx_npos;
                if (master) begin
                    out_lrclk_out <= lr_gen;
                end
                // four lines, slot order by position
                for (int k = 0; k < serial_port_pkg::LINES; k++) begin
                    serial_out_line[k] <= tx_map[8] && tx_sl[k][3] &&
                        tx_slot_reg[tx_sl[k][2:0]][tx_map[4:0]];
                end
            end
        end
    end

    // clock pins driven only as master
    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_bclk_oe   <= 1'b0;
            out_lrclk_oe  <= 1'b0;
            out_bclk_out  <= 1'b0;
            tx_frames_reg <= '0;
        end else begin
            out_bclk_oe  <= enable && master;
            out_lrclk_oe <= enable && master;
            out_bclk_out <= enable && master && (mbclk_reg ^ m_tick);
            if (tx_fall && tx_npos == 8'h00) begin
                tx_frames_reg <= tx_frames_reg + 8'h01;
            end
        end
    end

    // Receiver on the converter's bit clock
    logic [1:0]  rx_rst_sync_reg;
    logic [serial_port_pkg::CTRL_W-1:0] rcfg1_reg;
    logic [serial_port_pkg::CTRL_W-1:0] rcfg2_reg;
    logic [7:0]  rx_pos_reg;
    logic [7:0]  rx_p;
    logic        rx_prev_lr_reg;
    logic        rx_edge;
    logic        rx_tgl_reg;
    logic [9:0]  rx_map;
    logic [3:0]  rx_sl [serial_port_pkg::LINES];
    logic [23:0] rx_asm_reg [serial_port_pkg::LINES];
    logic [23:0] rx_hold_reg [serial_port_pkg::SLOTS];
    serial_port_pkg::fmt_t r_fmt;

    assign r_fmt   = serial_port_pkg::fmt_t'(rcfg2_reg[2:0]);
    assign rx_edge = falls_open(r_fmt) ? (rx_prev_lr_reg && !in_frame_clk) :
                                         (!rx_prev_lr_reg && in_frame_clk);
    assign rx_p    = rx_edge ? 8'h00 :
                     (rx_pos_reg == last_pos(r_fmt)) ? 8'h00 :
                     rx_pos_reg + 8'h01;
    assign rx_map  = bit_map(r_fmt, rcfg2_reg[serial_port_pkg::RJS_LSB +: 2],
                             rx_p);

    always_comb begin
        for (int k = 0; k < serial_port_pkg::LINES; k++) begin
            rx_sl[k] = slot_of(is_tdm(r_fmt), 2'(k), rx_map[7:5]);
        end
    end

    // Config is quasi-static: change it only while the port is disabled
    always_ff @(posedge rx_bit_clk) begin
        rx_rst_sync_reg <= {rx_rst_sync_reg[0], srst};
        rcfg1_reg       <= ctrl_reg;
        rcfg2_reg       <= rcfg1_reg;
    end

    // input clocks come only from the converter
    always_ff @(posedge rx_bit_clk) begin
        if (rx_rst_sync_reg[1] ||
            !rcfg2_reg[serial_port_pkg::ENABLE_BIT]) begin
            rx_pos_reg     <= last_pos(r_fmt);
            rx_prev_lr_reg <= 1'b0;
        end else begin
            rx_prev_lr_reg <= in_frame_clk;
            rx_pos_reg     <= rx_p;
            for (int k = 0; k < serial_port_pkg::LINES; k++) begin
                if (rx_map[8] && rx_sl[k][3]) begin
                    if (rx_map[4:0] == serial_port_pkg::TOP_BIT) begin
                        rx_asm_reg[k] <= {serial_in_line[k], 23'h000000};
                    end else begin
                        rx_asm_reg[k][rx_map[4:0]] <= serial_in_line[k];
                    end
                    if (rx_map[9]) begin
                        rx_hold_reg[rx_sl[k][2:0]] <= rx_asm_reg[k] |
                            (24'(serial_in_line[k]) << rx_map[4:0]);
                    end
                end
            end
        end
    end

    // Frame-end toggle; hold words stay put well past the copy
    always_ff @(posedge rx_bit_clk) begin
        if (rx_rst_sync_reg[1]) begin
            rx_tgl_reg <= 1'b0;
        end else if (rcfg2_reg[serial_port_pkg::ENABLE_BIT] &&
                     rx_p == last_pos(r_fmt)) begin
            rx_tgl_reg <= !rx_tgl_reg;
        end
    end

    logic [1:0] tgl_sync_reg;
    logic       tgl_seen_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tgl_sync_reg  <= '0;
            tgl_seen_reg  <= 1'b0;
            rx_frames_reg <= '0;
            for (int i = 0; i < serial_port_pkg::SLOTS; i++) begin
                rx_slot_reg[i] <= '0;
            end
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[0], rx_tgl_reg};
            tgl_seen_reg <= tgl_sync_reg[1];
            if (tgl_sync_reg[1] != tgl_seen_reg) begin
                rx_slot_reg   <= rx_hold_reg;
                rx_frames_reg <= rx_frames_reg + 8'h01;
            end
        end
    end

endmodule

// ===== test/serial_audio_port_sva.sv
module serial_audio_port_sva (
    // System
    input wire logic       core_clk,
    input wire logic       srst,
    // Register bus
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // Output port pins
    input wire logic       out_bclk_out,
    input wire logic       out_bclk_oe,
    input wire logic       out_lrclk_out,
    input wire logic       out_lrclk_oe,
    input wire logic [3:0] serial_out_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_oe_pair: assert property (out_bclk_oe == out_lrclk_oe)
        else $error("clock enables differ");
    a_reset_quiet: assert property ($past(srst) |->
        !s_axi_bvalid && !s_axi_rvalid && !out_bclk_oe)
        else $error("busy right after reset");
    a_data_on_fall: assert property ($changed(serial_out_line) &&
        out_bclk_oe && $past(out_bclk_oe) |-> $fell(out_bclk_out))
        else $error("data moved off a falling bit clock");
    a_frame_on_fall: assert property ($changed(out_lrclk_out) &&
        out_lrclk_oe && $past(out_lrclk_oe) |-> $fell(out_bclk_out))
        else $error("frame clock moved off a falling bit clock");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready)
        else $error("write response not retired");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer not in next cycle");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read answer not retired");
    c_frame: cover property ($fell(out_lrclk_out) && out_lrclk_oe);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind serial_audio_port serial_audio_port_sva u_sva (.*);

// ===== test/audio_converter_model.sv
module audio_converter_model (
    // Clocks and data toward the input port
    output logic             rx_bit_clk,
    output logic             in_frame_clk,
    output logic [3:0]       serial_in_line,
    // Words sent in every frame
    input  wire logic [23:0] left_word,
    input  wire logic [23:0] right_word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] pos = 6'h3f;
    initial begin
        rx_bit_clk = 1'h0;
        in_frame_clk = 1'h1;
        serial_in_line = 4'h0;
        // Converter owns the clocks; free running, odd phase
        #1.3;
        forever #24 rx_bit_clk = ~rx_bit_clk;
    end
    // I2S, 64 bits a frame, moved on falling edge
    always @(negedge rx_bit_clk) begin
        pos = pos + 6'h01;
        in_frame_clk <= pos[5];
        // Noise past the word
        if (pos[4:0] != 5'h00 && pos[4:0] <= 5'h18)
            serial_in_line <= {4{pos[5] ? right_word[24 - pos[4:0]]
                                        : left_word[24 - pos[4:0]]}};
        else
            serial_in_line <= 4'($urandom);
    end
endmodule

// ===== test/tb_serial_audio_port.sv
module tb_serial_audio_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'h0, srst = 1'h1, lr_prev = 1'h0, seen = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        out_bclk_out, out_bclk_oe, out_lrclk_out, out_lrclk_oe;
    logic        rx_bit_clk, in_frame_clk;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, serial_out_line, serial_in_line;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] left_word = 24'h0, right_word = 24'h0, tw[4];
    logic [95:0] sh_reg, tx_q[$];
    logic [33:0] rd_q[$];
    logic [5:0]  bpos = 6'h00;
    int          mismatches = 0, check_count = 0;
    // Released pins follow the converter's clocks
    wire         out_bclk_in = out_bclk_oe ? out_bclk_out : rx_bit_clk;
    wire         out_lrclk_in = out_lrclk_oe ? out_lrclk_out : in_frame_clk;

    serial_audio_port #(.BCLK_HALF(4)) DUT (.*);
    audio_converter_model u_conv (.*);

    initial forever #2 core_clk = ~core_clk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        fork
            begin
                do @(posedge core_clk); while (!s_axi_awready);
                s_axi_awvalid <= 1'h0;
            end
            begin
                do @(posedge core_clk); while (!s_axi_wready);
                s_axi_wvalid <= 1'h0;
            end
        join
        do @(posedge core_clk); while (!s_axi_bvalid);
        cmp_rd(34'h0, {s_axi_bresp, 32'h0});
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH resp_data exp %h seen %h", e, s);
        end
    endtask

    task automatic cmp_tx(input logic [95:0] e, input logic [95:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH tx left words exp %h seen %h", e, s);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready && rd_q.size() > 0)
            cmp_rd(rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    // Listener samples each line on the rising bit clock
    always @(posedge out_bclk_out) begin
        seen = seen | (lr_prev && !out_lrclk_out);
        bpos = (lr_prev && !out_lrclk_out) ? 6'h00 : bpos + 6'h01;
        lr_prev = out_lrclk_out;
        if (bpos >= 6'h01 && bpos <= 6'h18)
            for (int k = 0; k < 4; k++)
                sh_reg[k*24 +: 24] = {sh_reg[k*24 +: 23], serial_out_line[k]};
        if (seen && bpos == 6'h18 && tx_q.size() > 0)
            cmp_tx(tx_q.pop_front(), sh_reg);
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        $display("MISMATCH watchdog exp done seen hang");
        end_of_test;
    end

    initial begin
        void'($urandom(32'hc005cdc0));
        left_word = 24'($urandom);
        right_word = 24'($urandom);
        repeat (20) @(posedge core_clk);
        srst <= 1'h0;
        @(posedge core_clk);
        rd(serial_port_pkg::CTRL_OFS, 34'h0);
        rd(8'h10, {serial_port_pkg::RESP_DECERR, 32'h0});
        $display("test register map done");
        // Top byte lies beyond the word
        for (int k = 0; k < 4; k++) begin
            tw[k] = 24'($urandom);
            wr(serial_port_pkg::TX_BASE + 8'(8 * k), {8'($urandom), tw[k]});
        end
        rd(serial_port_pkg::TX_BASE + 8'h08, {10'h0, tw[1]});
        tx_q.push_back({tw[3], tw[2], tw[1], tw[0]});
        // Enable, master clocks, I2S
        wr(serial_port_pkg::CTRL_OFS, 32'h60);
        for (int n = 0; n < 4000 && tx_q.size() > 0; n++)
            @(posedge core_clk);
        if (tx_q.size() > 0) cmp_tx(tx_q.pop_front(), 'x);
        $display("test output frame done");
        repeat (2000) @(posedge core_clk);
        rd(serial_port_pkg::RX_BASE, {10'h0, left_word});
        rd(serial_port_pkg::RX_BASE + 8'h04, {10'h0, right_word});
        $display("test input frame done");
        end_of_test;
    end
endmodule
